// File: shared/wdw_pkg.sv
// package of offsets, fields, reset values and timing counts for the watchdog
package wdw_pkg;
   // register byte offsets on the apb
   localparam logic [7:0] OFF_WDT_CTRL = 8'h00;
   localparam logic [7:0] OFF_RST_CAUSE = 8'h04;
   localparam logic [7:0] OFF_WAKE_EN = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_COMMAND = 8'h18;
   // watchdog control fields and reset values
   localparam int KEY_LSB = 3;
   localparam int SEL_LSB = 0;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0a;
   localparam logic [7:0] WDT_CTRL_RST = 8'h53;
   // reset cause register fields
   localparam int RC_KEY_BIT = 0;
   localparam int RC_LVK_BIT = 1;
   localparam int RC_LV_BIT = 2;
   localparam int RC_PIN_BIT = 3;
   // status register fields
   localparam int ST_EXP_BIT = 0;
   localparam int ST_PD_BIT = 1;
   localparam int ST_EN_BIT = 2;
   localparam int ST_HALT_BIT = 3;
   // command register bits
   localparam int CMD_CLR_BIT = 0;
   localparam int CMD_HALT_BIT = 1;
   // interrupt status bits
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_KEYRST = 2;
   // software reset delay and pulse length
   localparam int SW_RST_DELAY_NS = 1000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SW_RST_DELAY_CYC =
      (SW_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_PULSE_CYC = 4;
   // wake cause codes
   typedef enum logic [2:0] {
      WK_NONE = 3'h0,
      WK_PORT = 3'h1,
      WK_PIN = 3'h2,
      WK_IRQ = 3'h3,
      WK_WDT = 3'h4
   } wdw_cause_e;
endpackage : wdw_pkg

// File: logic/wdw_sync.sv
// two-flop synchroniser for a bus of asynchronous inputs
module wdw_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } wdw_sync_s;
   wdw_sync_s r_q, r_d;

   // first stage only feeds the second stage
   always_comb begin
      r_d = r_q;
      r_d.s1 = din;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign dout = r_q.s2;
endmodule : wdw_sync

// File: logic/wdw_tick.sv
// edge detector turning the slow rc clock level into one-cycle ticks
module wdw_tick (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // synchronised slow clock level
   input wire logic osc_lvl,
   output logic tick
);
   typedef struct packed {
      logic last;
      logic tick;
   } wdw_tick_s;
   wdw_tick_s r_q, r_d;

   // one tick per rising edge of the slow clock
   always_comb begin
      r_d = r_q;
      r_d.last = osc_lvl;
      r_d.tick = osc_lvl & ~r_q.last;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign tick = r_q.tick;
endmodule : wdw_tick

// File: logic/wdw_top.sv
// watchdog timer and sleep wake-up logic with apb registers
// Function
// - in halt, wake on port a fall, reset pin, interrupt or overflow
// - reset pin wake gives full reset; overflow wake gives watchdog reset
// - power-down flag cleared at power-up and clear, set by halt
// - overflow in halt sets expired flag, resets only pc and sp
// - per-pin wake enable for port a falls; resume after halt
// - disabled interrupt or full stack: resume after halt, keep pending
// - enabled interrupt with free stack: vector at once on wake
// - interrupt already pending before halt cannot wake
// - watchdog counts the slow rc oscillator, ratio 2^8 to 2^18
// - timeout select maps codes to 2^8,10,12,14,15,16,17,18
// - bad key reset sets key reset flag; only software clears it
// - after power-on key is 01010 and timeout select 011
// - timeout in normal run resets device and sets expired flag
// - counter cleared by key reset, clear, halt, or reset pin low
// - halt clears counter; it runs only when enabled
// - halt sets power-down flag and clears expired flag
//
// Implementation choices: the APB interface to the registers and the register addresses.
module wdw_top #(
   parameter int PORT_W = 8,
   parameter int NIRQ = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // asynchronous pins
   input wire logic osc_slow,
   input wire logic [PORT_W-1:0] port_a,
   input wire logic ext_rst_pin_n,
   input wire logic reset_pin_select,
   // interrupt controller side, same clock
   input wire logic [NIRQ-1:0] irq_req,
   input wire logic [NIRQ-1:0] irq_en,
   input wire logic stack_full,
   // reset and wake outputs to the core
   output logic full_rst,
   output logic wdt_rst,
   output logic pcsp_rst,
   output logic resume,
   output logic irq_vector,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] cause;
      logic [PORT_W-1:0] wake_en;
      logic exp;
      logic pd;
      logic halted;
      logic [NIRQ-1:0] armed;
      logic [PORT_W-1:0] pa_last;
      logic [1:0] warm;
      logic [17:0] cnt;
      logic [7:0] dly;
      logic dly_run;
      logic [3:0] rst_cnt;
      logic [2:0] istat;
      logic [2:0] imask;
      logic full_rst;
      logic wdt_rst;
      logic pcsp_rst;
      logic resume;
      logic irq_vector;
      logic irq_out;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } wdw_top_s;
   wdw_top_s r_q, r_d;

   logic [PORT_W-1:0] pa_s;
   logic [1:0] pin_s;
   logic osc_tick;

   // port a, slow clock and reset pin cross into clk_sys through two flops
   wdw_sync #(.W(PORT_W)) u_sync_pa (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din(port_a),
      .dout(pa_s)
   );
   wdw_sync #(.W(2)) u_sync_pin (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din({osc_slow, ext_rst_pin_n}),
      .dout(pin_s)
   );
   wdw_tick u_tick (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .osc_lvl(pin_s[1]),
      .tick(osc_tick)
   );

   // timeout count for the selected ratio
   function automatic logic [17:0] limit(input logic [2:0] sel);
      logic [4:0] sh;
      sh = (sel < 3'h4) ? 5'(5'd8 + {sel, 1'b0}) : 5'(5'd11 + 5'(sel));
      limit = 18'(({1'b0, 18'h0} | 19'h1) << sh) - 18'h1;
   endfunction : limit

   logic acc, wr, rd, apb_hit, pin_low, en, key_bad, tmo;
   logic clr_cmd, halt_cmd, pa_fall, irq_wake;
   logic [4:0] key;

   always_comb begin
      r_d = r_q;
      acc = psel & penable & ~r_q.pready;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      key = r_q.ctrl[wdw_pkg::KEY_LSB +: 5];
      en = (key == wdw_pkg::KEY_ENABLE);
      key_bad = ~en & (key != wdw_pkg::KEY_DISABLE);
      // pin flops read low until filled after reset, so hold off two cycles
      pin_low = reset_pin_select & ~pin_s[0] & r_q.warm[1];
      clr_cmd = wr && paddr == wdw_pkg::OFF_COMMAND &&
         pwdata[wdw_pkg::CMD_CLR_BIT];
      halt_cmd = wr && paddr == wdw_pkg::OFF_COMMAND &&
         pwdata[wdw_pkg::CMD_HALT_BIT] && !r_q.halted;
      tmo = en && osc_tick &&
         r_q.cnt == limit(r_q.ctrl[wdw_pkg::SEL_LSB +: 3]);
      pa_fall = |(r_q.pa_last & ~pa_s & r_q.wake_en);
      irq_wake = |(irq_req & r_q.armed);
      apb_hit = 1'b1;
      r_d.pa_last = pa_s;
      r_d.warm = {r_q.warm[0], 1'b1};
      r_d.pready = acc;
      r_d.pslverr = 1'b0;
      r_d.prdata = 32'h0;
      r_d.full_rst = 1'b0;
      r_d.wdt_rst = 1'b0;
      r_d.pcsp_rst = 1'b0;
      r_d.resume = 1'b0;
      r_d.irq_vector = 1'b0;
      // watchdog counter
      if (en && osc_tick) begin
         r_d.cnt = r_q.cnt + 18'h1;
      end
      // an overflow restarts the divider, else a wake would wait a full wrap
      if (tmo) begin
         r_d.cnt = 18'h0;
      end
      if (clr_cmd) begin
         r_d.pd = 1'b0;
      end
      // register writes
      if (wr) begin
         unique case (paddr)
            wdw_pkg::OFF_WDT_CTRL: r_d.ctrl = pwdata[7:0];
            wdw_pkg::OFF_RST_CAUSE: r_d.cause = r_q.cause & pwdata[3:0];
            wdw_pkg::OFF_WAKE_EN: r_d.wake_en = pwdata[PORT_W-1:0];
            wdw_pkg::OFF_IRQ_STAT: r_d.istat = r_q.istat & ~pwdata[2:0];
            wdw_pkg::OFF_IRQ_MASK: r_d.imask = pwdata[2:0];
            wdw_pkg::OFF_COMMAND: ;
            default: apb_hit = 1'b0;
         endcase
      end
      if (rd) begin
         unique case (paddr)
            wdw_pkg::OFF_WDT_CTRL: r_d.prdata = {24'h0, r_q.ctrl};
            wdw_pkg::OFF_RST_CAUSE: r_d.prdata = {28'h0, r_q.cause};
            wdw_pkg::OFF_WAKE_EN: r_d.prdata = 32'(r_q.wake_en);
            wdw_pkg::OFF_STATUS: r_d.prdata = {28'h0, r_q.halted, en,
               r_q.pd, r_q.exp};
            wdw_pkg::OFF_IRQ_STAT: r_d.prdata = {29'h0, r_q.istat};
            wdw_pkg::OFF_IRQ_MASK: r_d.prdata = {29'h0, r_q.imask};
            wdw_pkg::OFF_COMMAND: r_d.prdata = 32'h0;
            default: apb_hit = 1'b0;
         endcase
      end
      r_d.pslverr = acc & ~apb_hit;
      // bad key arms the delayed software reset once
      if (key_bad && !r_q.dly_run) begin
         r_d.dly_run = 1'b1;
         r_d.dly = 8'h0;
      end else if (r_q.dly_run) begin
         r_d.dly = r_q.dly + 8'h1;
      end
      if (clr_cmd || halt_cmd || pin_low || key_bad) begin
         r_d.cnt = 18'h0;
      end
      // halt entry
      if (halt_cmd) begin
         r_d.halted = 1'b1;
         r_d.pd = 1'b1;
         r_d.exp = 1'b0;
         r_d.cnt = 18'h0;
         r_d.armed = ~irq_req;
      end
      // wake sources while halted
      if (r_q.halted) begin
         if (pin_low) begin
            r_d.halted = 1'b0;
            r_d.rst_cnt = 4'(wdw_pkg::RST_PULSE_CYC);
            r_d.istat[wdw_pkg::IRQ_WAKE] = 1'b1;
         end else if (tmo) begin
            r_d.halted = 1'b0;
            r_d.exp = 1'b1;
            r_d.wdt_rst = 1'b1;
            r_d.pcsp_rst = 1'b1;
            r_d.istat[wdw_pkg::IRQ_WAKE] = 1'b1;
            r_d.istat[wdw_pkg::IRQ_TIMEOUT] = 1'b1;
         end else if (pa_fall || irq_wake) begin
            r_d.halted = 1'b0;
            r_d.istat[wdw_pkg::IRQ_WAKE] = 1'b1;
            if (irq_wake && |(irq_req & r_q.armed & irq_en) && !stack_full) begin
               r_d.irq_vector = 1'b1;
            end else begin
               r_d.resume = 1'b1;
            end
         end
      end else if (tmo) begin
         r_d.exp = 1'b1;
         r_d.rst_cnt = 4'(wdw_pkg::RST_PULSE_CYC);
         r_d.istat[wdw_pkg::IRQ_TIMEOUT] = 1'b1;
      end
      // delayed key reset
      if (r_q.dly_run && r_q.dly == 8'(wdw_pkg::SW_RST_DELAY_CYC - 1)) begin
         r_d.dly_run = 1'b0;
         r_d.cause[wdw_pkg::RC_KEY_BIT] = 1'b1;
         r_d.rst_cnt = 4'(wdw_pkg::RST_PULSE_CYC);
         r_d.istat[wdw_pkg::IRQ_KEYRST] = 1'b1;
      end
      // device reset pulse restores control defaults
      if (r_q.rst_cnt != 4'h0) begin
         r_d.rst_cnt = r_q.rst_cnt - 4'h1;
         r_d.full_rst = 1'b1;
         r_d.ctrl = wdw_pkg::WDT_CTRL_RST;
         r_d.cnt = 18'h0;
         r_d.halted = 1'b0;
         r_d.dly_run = 1'b0;
      end
      r_d.irq_out = |(r_d.istat & r_d.imask);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r_q <= '0;
         r_q.ctrl <= wdw_pkg::WDT_CTRL_RST;
         r_q.pd <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.prdata;
   assign pready = r_q.pready;
   assign pslverr = r_q.pslverr;
   assign full_rst = r_q.full_rst;
   assign wdt_rst = r_q.wdt_rst;
   assign pcsp_rst = r_q.pcsp_rst;
   assign resume = r_q.resume;
   assign irq_vector = r_q.irq_vector;
   assign irq_out = r_q.irq_out;

   // checks kept beside the logic; all sample on clk_sys, quiet in reset
   chk_halt_flags: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      halt_cmd && r_q.rst_cnt == 4'h0 |=> r_q.pd && !r_q.exp && r_q.halted)
      else $error("halt flags wrong");
   chk_halt_cnt: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      halt_cmd |=> r_q.cnt == 18'h0)
      else $error("halt did not clear counter");
   chk_clr_pd: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      clr_cmd && !halt_cmd |=> !r_q.pd)
      else $error("clear kept power-down flag");
   chk_wdt_wake: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && tmo && !pin_low && r_q.rst_cnt == 4'h0
      |=> r_q.wdt_rst && r_q.pcsp_rst && r_q.exp && !r_q.full_rst)
      else $error("watchdog wake wrong");
   chk_run_tmo: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      !r_q.halted && tmo |=> ##1 r_q.full_rst [*4])
      else $error("timeout reset missing");
   chk_key_rst: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      key_bad && !r_q.dly_run && r_q.rst_cnt == 4'h0
      |-> ##[1:60] r_q.cause[wdw_pkg::RC_KEY_BIT])
      else $error("bad key did not reset");
   chk_key_sticky: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.cause[wdw_pkg::RC_KEY_BIT] && !wr
      |=> r_q.cause[wdw_pkg::RC_KEY_BIT])
      else $error("key flag cleared by hardware");
   chk_port_wake: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && pa_fall && !pin_low && !tmo && !irq_wake
      && r_q.rst_cnt == 4'h0 |=> r_q.resume && !r_q.halted)
      else $error("port wake missed");
   chk_no_count: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      !en && r_q.rst_cnt == 4'h0
      |=> r_q.cnt <= $past(r_q.cnt))
      else $error("counter ran while disabled");
   // wake priority and the interrupt response on wake
   chk_pin_wake: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && pin_low && r_q.rst_cnt == 4'h0
      |=> !r_q.halted && !r_q.wdt_rst ##1 r_q.full_rst [*4])
      else $error("pin wake did not reset");
   chk_irq_vector: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && irq_wake && !pin_low && !tmo && r_q.rst_cnt == 4'h0
      && |(irq_req & r_q.armed & irq_en) && !stack_full
      |=> r_q.irq_vector && !r_q.resume && !r_q.halted)
      else $error("enabled wake interrupt not taken");
   chk_irq_resume: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && irq_wake && !pin_low && !tmo && r_q.rst_cnt == 4'h0
      && (!(|(irq_req & r_q.armed & irq_en)) || stack_full)
      |=> r_q.resume && !r_q.irq_vector && !r_q.halted)
      else $error("held wake interrupt did not resume");
   chk_pend_no_wake: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.halted && !pin_low && !tmo && !pa_fall && r_q.rst_cnt == 4'h0
      && (irq_req & r_q.armed) == '0 |=> r_q.halted)
      else $error("pending interrupt woke the device");
   chk_pend_disarm: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      halt_cmd |=> (r_q.armed & $past(irq_req)) == '0)
      else $error("pending interrupt left armed");
   // counter restart and reset pulse shape
   chk_tmo_restart: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      tmo |=> r_q.cnt == 18'h0)
      else $error("counter kept running past timeout");
   chk_pulse_len: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      $rose(r_q.full_rst) |-> r_q.full_rst [*4] ##1 !r_q.full_rst)
      else $error("device reset pulse length wrong");
   chk_ctrl_restore: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      r_q.full_rst |-> r_q.ctrl == wdw_pkg::WDT_CTRL_RST)
      else $error("reset pulse left control unrestored");
   // main scenarios reached
   cov_halt: cover property (@(posedge clk_sys) halt_cmd);
   cov_wdt_wake: cover property (@(posedge clk_sys) r_q.pcsp_rst);
   cov_irq_vec: cover property (@(posedge clk_sys) r_q.irq_vector);
   cov_port_wake: cover property (@(posedge clk_sys) r_q.resume);
   cov_key_rst: cover property (@(posedge clk_sys)
      r_q.cause[wdw_pkg::RC_KEY_BIT]);
endmodule : wdw_top

// File: tb/wdw_top_bench.sv
// self-checking bench for the watchdog and wake-up block
module wdw_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rd_err, osc_slow = 1'h0;
   logic ext_rst_pin_n = 1'h1, reset_pin_select = 1'h0;
   logic [7:0] port_a = 8'hff;
   logic [3:0] irq_req = 4'h0, irq_en = 4'h0;
   logic stack_full = 1'h0;
   logic full_rst, wdt_rst, pcsp_rst, resume, irq_vector, irq_out;
   logic [4:0] pv = 5'h00;
   int seen[5] = '{default: 0};
   int exp_n[5] = '{default: 0};
   int error_cnt = 0, total_checks = 0, cyc = 0, seed = 1;
   wire [4:0] outs = {full_rst, wdt_rst, pcsp_rst, resume, irq_vector};

   // free-running system clock
   always #12.5 clk_sys = ~clk_sys;

   wdw_top wdw_top_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_slow(osc_slow),
      .port_a(port_a), .ext_rst_pin_n(ext_rst_pin_n),
      .reset_pin_select(reset_pin_select), .irq_req(irq_req),
      .irq_en(irq_en), .stack_full(stack_full), .full_rst(full_rst),
      .wdt_rst(wdt_rst), .pcsp_rst(pcsp_rst), .resume(resume),
      .irq_vector(irq_vector), .irq_out(irq_out)
   );

   // count each core pulse once per rise; a hang ends the run as a miss
   always @(posedge clk_sys) begin
      pv <= outs;
      for (int k = 0; k < 5; k++) begin
         if (outs[k] === 1'h1 && pv[k] !== 1'h1) seen[k]++;
      end
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task chk(input string nm, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n == 20) error_cnt++;
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // slow clock cycles; 4 system cycles per phase outlast the synchroniser
   task ticks(input int n);
      repeat (n) begin
         wt(4);
         osc_slow <= 1'h1;
         wt(4);
         osc_slow <= 1'h0;
      end
      wt(6);
   endtask : ticks

   task chk_pulses();
      wt(2);
      for (int k = 0; k < 5; k++) chk($sformatf("pulse %0d", k), seen[k],
         exp_n[k]);
   endtask : chk_pulses

   task halt();
      apb(1'h1, wdw_pkg::OFF_COMMAND, 32'h2);
   endtask : halt

   task wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   // main sequence
   initial begin
      int pin;
      wt(2);
      rst_n <= 1'h1;
      apb(1'h0, wdw_pkg::OFF_WDT_CTRL, 32'h0);
      chk("ctrl rst", rd, 32'h53);
      apb(1'h0, wdw_pkg::OFF_STATUS, 32'h0);
      chk("status rst", rd & 32'hf, 32'h4);
      apb(1'h0, 8'h40, 32'h0);
      chk("unmapped", {31'h0, rd_err}, 32'h1);
      // timeout boundary for the two shortest select codes
      for (int s = 0; s < 2; s++) begin
         apb(1'h1, wdw_pkg::OFF_WDT_CTRL, 32'h50 + s);
         apb(1'h1, wdw_pkg::OFF_COMMAND, 32'h1);
         ticks((256 << (2 * s)) - 1);
         chk_pulses();
         ticks(1);
         exp_n[4]++;
         chk_pulses();
      end
      apb(1'h0, wdw_pkg::OFF_STATUS, 32'h0);
      chk("expired", rd & 32'h1, 32'h1);
      // interrupt raised, masked and cleared
      apb(1'h1, wdw_pkg::OFF_IRQ_MASK, 32'h1);
      wt(3);
      chk("irq on", {31'h0, irq_out}, 32'h1);
      apb(1'h1, wdw_pkg::OFF_IRQ_MASK, 32'h0);
      wt(3);
      chk("irq masked", {31'h0, irq_out}, 32'h0);
      apb(1'h1, wdw_pkg::OFF_IRQ_MASK, 32'h1);
      apb(1'h1, wdw_pkg::OFF_IRQ_STAT, 32'h1);
      wt(3);
      chk("irq clr", {31'h0, irq_out}, 32'h0);
      // disabled watchdog never fires; a clear restarts the count
      apb(1'h1, wdw_pkg::OFF_WDT_CTRL, 32'ha8);
      ticks(300);
      chk_pulses();
      apb(1'h1, wdw_pkg::OFF_WDT_CTRL, 32'h50);
      ticks(200);
      apb(1'h1, wdw_pkg::OFF_COMMAND, 32'h1);
      ticks(200);
      chk_pulses();
      // halt flags, then a port a fall on a random enabled pin
      pin = $unsigned($random(seed)) % 8;
      apb(1'h1, wdw_pkg::OFF_WAKE_EN, 32'h1 << pin);
      halt();
      apb(1'h0, wdw_pkg::OFF_STATUS, 32'h0);
      chk("halt status", rd & 32'hf, 32'he);
      port_a[(pin + 1) % 8] <= 1'h0;
      wt(10);
      chk_pulses();
      port_a[pin] <= 1'h0;
      wt(10);
      exp_n[1]++;
      chk_pulses();
      port_a <= 8'hff;
      apb(1'h1, wdw_pkg::OFF_COMMAND, 32'h1);
      apb(1'h0, wdw_pkg::OFF_STATUS, 32'h0);
      chk("pd clr", rd & 32'hf, 32'h4);
      // overflow during halt resets only pc and sp
      halt();
      ticks(256);
      exp_n[3]++;
      exp_n[2]++;
      chk_pulses();
      apb(1'h0, wdw_pkg::OFF_STATUS, 32'h0);
      chk("halt expiry", rd & 32'h3, 32'h3);
      // interrupt wake: enabled, disabled, enabled with full stack
      for (int i = 0; i < 3; i++) begin
         halt();
         irq_en[i] <= (i != 1);
         stack_full <= (i == 2);
         irq_req[i] <= 1'h1;
         wt(10);
         if (i == 0) exp_n[0]++;
         else exp_n[1]++;
         chk_pulses();
      end
      // requests still pending at halt cannot wake; reset pin does
      halt();
      wt(10);
      chk_pulses();
      reset_pin_select <= 1'h1;
      ext_rst_pin_n <= 1'h0;
      wt(3);
      ext_rst_pin_n <= 1'h1;
      reset_pin_select <= 1'h0;
      wt(10);
      exp_n[4]++;
      chk_pulses();
      // bad key value: delayed reset and sticky cause flag
      apb(1'h1, wdw_pkg::OFF_WDT_CTRL, 32'h0);
      wt(30);
      chk_pulses();
      wt(15);
      exp_n[4]++;
      chk_pulses();
      apb(1'h0, wdw_pkg::OFF_RST_CAUSE, 32'h0);
      chk("key flag", rd & 32'h1, 32'h1);
      apb(1'h1, wdw_pkg::OFF_RST_CAUSE, 32'h1);
      apb(1'h0, wdw_pkg::OFF_RST_CAUSE, 32'h0);
      chk("key keep", rd & 32'h1, 32'h1);
      apb(1'h1, wdw_pkg::OFF_RST_CAUSE, 32'h0);
      apb(1'h0, wdw_pkg::OFF_RST_CAUSE, 32'h0);
      chk("key clr", rd & 32'h1, 32'h0);
      wrap_up();
   end
endmodule : wdw_top_bench
